// *** design/saipc_pkg.sv ***
/*
 * Constants of the acquisition and interrupt pin block:
 * addresses, field positions, masks, resets and the
 * spacing table.
 * Assumes it is compiled first.
 */
package saipc_pkg;

   // Register addresses on the byte-wide register port.
   localparam logic [7:0] ADDR_CTRL1 = 8'h26;
   localparam logic [7:0] ADDR_CTRL2 = 8'h27;
   localparam logic [7:0] ADDR_CTRL3 = 8'h28;
   localparam logic [7:0] REG_RESET  = 8'h00;

   // Writable bits of each register; everything else is reserved.
   localparam logic [7:0] CTRL1_WMASK = 8'h3B;
   localparam logic [7:0] CTRL2_WMASK = 8'h3F;
   localparam logic [7:0] CTRL3_WMASK = 8'h33;

   // Field positions in control one.
   localparam int unsigned OS_LSB     = 3;
   localparam int unsigned OS_W       = 3;
   localparam int unsigned SHOT_BIT   = 1;
   localparam int unsigned ACTIVE_BIT = 0;

   // Field positions in control two.
   localparam int unsigned LOAD_BIT = 5;
   localparam int unsigned TSEL_BIT = 4;
   localparam int unsigned STEP_LSB = 0;
   localparam int unsigned STEP_W   = 4;

   // Field positions in control three.
   localparam int unsigned IRQA_POL_BIT = 5;
   localparam int unsigned IRQA_DRV_BIT = 4;
   localparam int unsigned IRQB_POL_BIT = 1;
   localparam int unsigned IRQB_DRV_BIT = 0;

   // Timing: clock rate, one second in milliseconds, counter widths.
   localparam int unsigned CLK_FREQ_HZ = 200_000_000;
   localparam int unsigned MS_PER_S    = 1000;
   localparam int unsigned TICKS_PER_MS_DEF = CLK_FREQ_HZ / MS_PER_S;
   localparam int unsigned SPACE_W     = 10;
   localparam int unsigned IVAL_W      = 26;

   // Least time between samples in milliseconds, indexed by oversample code.
   localparam logic [SPACE_W-1:0] SPACING_MS [8] = '{
      10'h006, 10'h00A, 10'h012, 10'h022,
      10'h042, 10'h082, 10'h102, 10'h200};

   // Acquisition sequencer states.
   typedef enum logic [0:0] {ACQ_IDLE, ACQ_BUSY} saipc_acq_t;

endpackage

// *** design/saipc_acq_if.sv ***
/*
 * Link from register core to acquisition timer.
 * Assumes one shared clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface saipc_acq_if;
   logic                         activeMode;
   logic [saipc_pkg::STEP_W-1:0]  intervalExp;
   logic [saipc_pkg::SPACE_W-1:0] spacingMs;
   logic                         measStart;
   logic                         intervalDue;
   logic                         spacingOk;

   modport core  (output activeMode, intervalExp, spacingMs, measStart,
                  input intervalDue, spacingOk);
   modport timer (input activeMode, intervalExp, spacingMs, measStart,
                  output intervalDue, spacingOk);
endinterface

`default_nettype wire

// *** design/saipc_acq_timer.sv ***
/*
 * Millisecond prescaler, interval counter and
 * spacing guard.
 * Assumes one clock shared with the core.
 */
`timescale 1ns/1ps
`default_nettype none

module saipc_acq_timer #(
   parameter int unsigned TICKS_PER_MS = saipc_pkg::TICKS_PER_MS_DEF
) (
   // Clock and control.
   input wire logic      sys_clk,
   input wire logic      reset,
   input wire logic      clkEn,
   // Link to the register core.
   saipc_acq_if.timer    acq
);
   localparam int unsigned PRE_W = $clog2(TICKS_PER_MS + 1);

   logic [PRE_W-1:0]              preCnt_ff;
   logic [saipc_pkg::IVAL_W-1:0]  ivalCnt_ff;
   logic [saipc_pkg::SPACE_W:0]   spaceCnt_ff;
   logic                          msTick;
   logic [saipc_pkg::IVAL_W-1:0]  ivalLast;
   logic                          ivalWrap;

   // The interval in ms is one second shifted left by the step exponent.
   assign msTick   = (preCnt_ff == PRE_W'(TICKS_PER_MS - 1));
   assign ivalLast = (saipc_pkg::IVAL_W'(saipc_pkg::MS_PER_S)
                      << acq.intervalExp) - 1'b1;
   assign ivalWrap = msTick && (ivalCnt_ff >= ivalLast);
   assign acq.intervalDue = acq.activeMode && ivalWrap;
   assign acq.spacingOk   = (spaceCnt_ff == '0);

   // Prescaler runs freely; one tick per millisecond.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         preCnt_ff <= '0;
      end else if (clkEn) begin
         preCnt_ff <= msTick ? '0 : preCnt_ff + 1'b1;
      end
   end

   // Interval counter restarts whenever standby is selected.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ivalCnt_ff <= '0;
      end else if (clkEn) begin
         if (!acq.activeMode || ivalWrap) begin
            ivalCnt_ff <= '0;
         end else if (msTick) begin
            ivalCnt_ff <= ivalCnt_ff + 1'b1;
         end
      end
   end

   // One extra tick is loaded so the phase of the prescaler can never
   // shorten the guard below the least spacing.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         spaceCnt_ff <= '0;
      end else if (clkEn) begin
         if (acq.measStart) begin
            spaceCnt_ff <= {1'b0, acq.spacingMs} + 1'b1;
         end else if (msTick && spaceCnt_ff != '0) begin
            spaceCnt_ff <= spaceCnt_ff - 1'b1;
         end
      end
   end

   initial begin
      if (TICKS_PER_MS < 2) $error("TICKS_PER_MS must be at least 2");
   end
endmodule

`default_nettype wire

// *** design/saipc_irq_pin.sv ***
/*
 * Driver of one interrupt pin: polarity and
 * drive mode, outputs registered.
 * Assumes the pad combines the three outputs.
 */
`timescale 1ns/1ps
`default_nettype none

module saipc_irq_pin (
   // Clock and control.
   input wire logic  sys_clk,
   input wire logic  reset,
   input wire logic  clkEn,
   // Event and configuration, taken from next-state values.
   input wire logic  irqReq,
   input wire logic  polarity,
   input wire logic  driveMode,
   // Pad.
   output logic      padOut,
   output logic      padOeN,
   output logic      pullUpEn
);
   logic level;

   // Asserted level equals the polarity bit; idle level is its inverse.
   assign level = irqReq ? polarity : ~polarity;

   // Open drain only pulls low; a high level is left to the line.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         padOut   <= 1'b1;
         padOeN   <= 1'b0;
         pullUpEn <= 1'b1;
      end else if (clkEn) begin
         padOut   <= driveMode ? 1'b0 : level;
         padOeN   <= driveMode ? level : 1'b0;
         pullUpEn <= ~driveMode;
      end
   end
endmodule

`default_nettype wire

// *** design/saipc_top.sv ***
/*
 * Register core: control one, two and three,
 * the acquisition sequencer,
 * target capture and the two interrupt pins.
 * Assumes a decoded register port and a
 * datapath on this clock that answers a start
 * with a one-cycle done pulse.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Oversample code picks ratio 1..128 and least spacing 6..512 ms.
// - Load-target bit set captures the next results as targets.
// - One capture per setting; host clears and sets again for more.
// - Target-select zero uses programmed targets, one uses captured.
// - Step field sets the interval to two to the field seconds.
// - Pin A polarity bit: zero active low, one active high.
// - Pin A drive bit: zero push-pull with pull-up, one open drain.
// - Pin B polarity bit: zero active low, one active high.
// - Pin B drive bit: zero push-pull with pull-up, one open drain.
// - Reserved bits are read-only and read zero.
// - Oversample code sits in control one bits 5 to 3, reset 000.
// - Active bit set measures periodically; clear means standby.
// - Single shot starts once idle and the spacing guard allows; self-clears only in standby.
module saipc_top #(
   parameter int unsigned TICKS_PER_MS = saipc_pkg::TICKS_PER_MS_DEF,
   parameter int unsigned PRESS_W      = 20,
   parameter int unsigned TEMP_W       = 12
) (
   // Clock, reset and clock enable.
   input wire logic                sys_clk,
   input wire logic                reset,
   input wire logic                clkEn,
   // Register port.
   input wire logic [7:0]          regAddr,
   input wire logic                regWrEn,
   input wire logic [7:0]          regWrData,
   input wire logic                regRdEn,
   output logic [7:0]              regRdData,
   // Measurement datapath.
   output logic                    measStart,
   output logic [saipc_pkg::OS_W-1:0] measOsCode,
   output logic                    measBusy,
   input wire logic                measDone,
   input wire logic [PRESS_W-1:0]  resultPressure,
   input wire logic [TEMP_W-1:0]   resultTemp,
   // Targets for the window and threshold comparators.
   input wire logic [PRESS_W-1:0]  progPressTarget,
   input wire logic [TEMP_W-1:0]   progTempTarget,
   output logic [PRESS_W-1:0]      targetPressure,
   output logic [TEMP_W-1:0]       targetTemp,
   output logic                    capturedValid,
   // Routed interrupt requests, active high.
   input wire logic                irqAReq,
   input wire logic                irqBReq,
   // Interrupt pin A pad.
   output logic                    irqPinAOut,
   output logic                    irqPinAOeN,
   output logic                    irqPinAPullUp,
   // Interrupt pin B pad.
   output logic                    irqPinBOut,
   output logic                    irqPinBOeN,
   output logic                    irqPinBPullUp
);

   // Register storage and next values.
   logic [7:0] ctrl1_ff;
   logic [7:0] ctrl2_ff;
   logic [7:0] ctrl3_ff;
   logic [7:0] nxt_ctrl1;
   logic [7:0] nxt_ctrl2;
   logic [7:0] nxt_ctrl3;

   // Sequencer state.
   saipc_pkg::saipc_acq_t acqState_ff;
   saipc_pkg::saipc_acq_t nxt_acqState;
   logic shotReq_ff;
   logic shotInFlight_ff;
   logic dueLatch_ff;
   logic loadArmed_ff;
   logic [PRESS_W-1:0] capPress_ff;
   logic [TEMP_W-1:0]  capTemp_ff;

   // Address decode and write strobes.
   logic hitCtrl1;
   logic hitCtrl2;
   logic hitCtrl3;
   logic wrCtrl1;
   logic wrCtrl2;
   logic wrCtrl3;
   assign hitCtrl1 = (regAddr == saipc_pkg::ADDR_CTRL1);
   assign hitCtrl2 = (regAddr == saipc_pkg::ADDR_CTRL2);
   assign hitCtrl3 = (regAddr == saipc_pkg::ADDR_CTRL3);
   assign wrCtrl1  = regWrEn && hitCtrl1;
   assign wrCtrl2  = regWrEn && hitCtrl2;
   assign wrCtrl3  = regWrEn && hitCtrl3;

   // Fields as seen by the logic.
   logic       activeBit;
   logic       shotBit;
   logic       loadBit;
   logic       tselBit;
   logic [saipc_pkg::OS_W-1:0]   osCode;
   logic [saipc_pkg::STEP_W-1:0] stepExp;
   assign activeBit = ctrl1_ff[saipc_pkg::ACTIVE_BIT];
   assign shotBit   = ctrl1_ff[saipc_pkg::SHOT_BIT];
   assign loadBit   = ctrl2_ff[saipc_pkg::LOAD_BIT];
   assign tselBit   = ctrl2_ff[saipc_pkg::TSEL_BIT];
   assign osCode    = ctrl1_ff[saipc_pkg::OS_LSB +: saipc_pkg::OS_W];
   assign stepExp   = ctrl2_ff[saipc_pkg::STEP_LSB +: saipc_pkg::STEP_W];

   // Writes are masked so reserved bits can never hold a one.
   logic [7:0] wrVal1;
   logic [7:0] wrVal2;
   logic [7:0] wrVal3;
   assign wrVal1 = regWrData & saipc_pkg::CTRL1_WMASK;
   assign wrVal2 = regWrData & saipc_pkg::CTRL2_WMASK;
   assign wrVal3 = regWrData & saipc_pkg::CTRL3_WMASK;

   // Rising edges of the bits that launch something when written to one.
   logic shotRise;
   logic loadRise;
   assign shotRise = wrCtrl1 && wrVal1[saipc_pkg::SHOT_BIT] && !shotBit;
   assign loadRise = wrCtrl2 && wrVal2[saipc_pkg::LOAD_BIT] && !loadBit;

   // Sequencer decisions.
   saipc_acq_if acq ();
   logic launch;
   logic shotDone;
   assign launch = (acqState_ff == saipc_pkg::ACQ_IDLE) && acq.spacingOk
                   && (shotReq_ff || (dueLatch_ff && activeBit));
   assign shotDone = (acqState_ff == saipc_pkg::ACQ_BUSY) && measDone
                     && shotInFlight_ff;

   // In standby the shot bit clears when its measurement ends; a host
   // write of one in that same cycle is overridden unless the bit already reads zero.
   always_comb begin
      nxt_ctrl1 = wrCtrl1 ? wrVal1 : ctrl1_ff;
      if (shotDone && !activeBit && !shotRise) begin
         nxt_ctrl1[saipc_pkg::SHOT_BIT] = 1'b0;
      end
   end
   assign nxt_ctrl2 = wrCtrl2 ? wrVal2 : ctrl2_ff;
   assign nxt_ctrl3 = wrCtrl3 ? wrVal3 : ctrl3_ff;

   // Control registers; all fields reset to zero.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl1_ff <= saipc_pkg::REG_RESET;
         ctrl2_ff <= saipc_pkg::REG_RESET;
         ctrl3_ff <= saipc_pkg::REG_RESET;
      end else if (clkEn) begin
         ctrl1_ff <= nxt_ctrl1;
         ctrl2_ff <= nxt_ctrl2;
         ctrl3_ff <= nxt_ctrl3;
      end
   end

   // Read data is registered; reserved bits and unmapped addresses read 0.
   logic [7:0] rdMux;
   assign rdMux = hitCtrl1 ? ctrl1_ff :
                  hitCtrl2 ? ctrl2_ff :
                  hitCtrl3 ? ctrl3_ff : saipc_pkg::REG_RESET;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         regRdData <= saipc_pkg::REG_RESET;
      end else if (clkEn && regRdEn) begin
         regRdData <= rdMux;
      end
   end

   // Sequencer state transition.
   always_comb begin
      nxt_acqState = acqState_ff;
      unique case (acqState_ff)
         saipc_pkg::ACQ_IDLE: begin
            if (launch) nxt_acqState = saipc_pkg::ACQ_BUSY;
         end
         saipc_pkg::ACQ_BUSY: begin
            if (measDone) nxt_acqState = saipc_pkg::ACQ_IDLE;
         end
      endcase
   end

   // A shot request stays pending until the spacing guard lets it run;
   // an interval that falls due while busy is remembered, not dropped.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         acqState_ff     <= saipc_pkg::ACQ_IDLE;
         shotReq_ff      <= 1'b0;
         shotInFlight_ff <= 1'b0;
         dueLatch_ff     <= 1'b0;
      end else if (clkEn) begin
         acqState_ff <= nxt_acqState;
         if (shotRise) begin
            shotReq_ff <= 1'b1;
         end else if (launch) begin
            shotReq_ff <= 1'b0;
         end
         if (launch) begin
            shotInFlight_ff <= shotReq_ff;
         end
         if (acq.intervalDue) begin
            dueLatch_ff <= 1'b1;
         end else if (launch || !activeBit) begin
            dueLatch_ff <= 1'b0;
         end
      end
   end

   // Start pulse and the code given to the datapath come from flip-flops.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         measStart  <= 1'b0;
         measOsCode <= '0;
      end else if (clkEn) begin
         measStart  <= launch;
         measOsCode <= osCode;
      end
   end
   assign measBusy = (acqState_ff == saipc_pkg::ACQ_BUSY);

   // Timer link: the guard is loaded when the start leaves the core.
   assign acq.activeMode  = activeBit;
   assign acq.intervalExp = stepExp;
   assign acq.spacingMs   = saipc_pkg::SPACING_MS[osCode];
   assign acq.measStart   = launch;

   saipc_acq_timer #(
      .TICKS_PER_MS (TICKS_PER_MS)
   ) u_timer (
      .sys_clk (sys_clk),
      .reset   (reset),
      .clkEn   (clkEn),
      .acq     (acq)
   );

   // The arm is set by each new setting of the load bit and spent by the
   // first result that follows, so one setting captures exactly once.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         loadArmed_ff  <= 1'b0;
         capPress_ff   <= '0;
         capTemp_ff    <= '0;
         capturedValid <= 1'b0;
      end else if (clkEn) begin
         if (loadRise) begin
            loadArmed_ff <= 1'b1;
         end else if (measDone && loadArmed_ff) begin
            loadArmed_ff <= 1'b0;
         end
         if (measDone && loadArmed_ff) begin
            capPress_ff   <= resultPressure;
            capTemp_ff    <= resultTemp;
            capturedValid <= 1'b1;
         end
      end
   end

   // Comparator reference follows the select bit one cycle later.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         targetPressure <= '0;
         targetTemp     <= '0;
      end else if (clkEn) begin
         targetPressure <= tselBit ? capPress_ff : progPressTarget;
         targetTemp     <= tselBit ? capTemp_ff : progTempTarget;
      end
   end

   // Pins take next-state configuration so a write shows one cycle later.
   saipc_irq_pin u_pin_a (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .clkEn     (clkEn),
      .irqReq    (irqAReq),
      .polarity  (nxt_ctrl3[saipc_pkg::IRQA_POL_BIT]),
      .driveMode (nxt_ctrl3[saipc_pkg::IRQA_DRV_BIT]),
      .padOut    (irqPinAOut),
      .padOeN    (irqPinAOeN),
      .pullUpEn  (irqPinAPullUp)
   );

   saipc_irq_pin u_pin_b (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .clkEn     (clkEn),
      .irqReq    (irqBReq),
      .polarity  (nxt_ctrl3[saipc_pkg::IRQB_POL_BIT]),
      .driveMode (nxt_ctrl3[saipc_pkg::IRQB_DRV_BIT]),
      .padOut    (irqPinBOut),
      .padOeN    (irqPinBOeN),
      .pullUpEn  (irqPinBPullUp)
   );

   // Widths the capture and comparator paths can serve.
   initial begin
      if (PRESS_W < 1 || PRESS_W > 32) $error("PRESS_W out of range");
      if (TEMP_W < 1 || TEMP_W > 32) $error("TEMP_W out of range");
   end

endmodule

`default_nettype wire

// *** verif/saipc_meas_model.sv ***
/* Measurement datapath model.
   Assumes the bench sets nextP and nextT. */
`timescale 1ns/1ps
`default_nettype none
module saipc_meas_model #(
   parameter int unsigned DELAY = 20
) (
   // Clock and reset.
   input wire logic        sys_clk,
   input wire logic        reset,
   // Start from the block and values from the bench.
   input wire logic        measStart,
   input wire logic [19:0] nextP,
   input wire logic [11:0] nextT,
   // Done pulse and results.
   output logic            measDone,
   output logic [19:0]     resultPressure,
   output logic [11:0]     resultTemp
);
   int cnt;

   // Done DELAY cycles after a start.
   always @(posedge sys_clk) begin
      measDone <= 1'b0;
      if (reset) begin
         cnt <= 0;
      end else if (measStart) begin
         cnt <= DELAY;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         measDone <= (cnt == 1);
      end
   end

   // Off the done cycle the lines show the inverse.
   assign resultPressure = measDone ? nextP : ~nextP;
   assign resultTemp     = measDone ? nextT : ~nextT;
endmodule
`default_nettype wire

// *** verif/saipc_top_checker.sv ***
/* Port-level assertions for saipc_top.
   Assumes one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module saipc_top_checker #(
   parameter int unsigned TICKS_PER_MS = 4
) (
   // Clock and reset.
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic       clkEn,
   // Register port.
   input wire logic [7:0] regAddr,
   input wire logic       regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic       regRdEn,
   input wire logic [7:0] regRdData,
   // Measurement.
   input wire logic       measStart,
   input wire logic [saipc_pkg::OS_W-1:0] measOsCode,
   input wire logic       measBusy,
   input wire logic       measDone,
   // Interrupt requests and pads.
   input wire logic       irqAReq,
   input wire logic       irqBReq,
   input wire logic       irqPinAOut,
   input wire logic       irqPinAOeN,
   input wire logic       irqPinAPullUp,
   input wire logic       irqPinBOut,
   input wire logic       irqPinBOeN,
   input wire logic       irqPinBPullUp
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   logic [15:0] gap_ff;
   logic [15:0] nxt_gap;
   logic [2:0]  lastOs_ff;
   logic [31:0] minGap;
   logic [7:0]  rdMask;

   // Saturates so a long idle never wraps short.
   assign nxt_gap = !clkEn ? gap_ff : measStart ? 16'h0001 :
                    gap_ff + {15'h0000, gap_ff != 16'hFFFF};
   assign minGap = 32'(saipc_pkg::SPACING_MS[lastOs_ff]) * TICKS_PER_MS;
   assign rdMask = (regAddr == saipc_pkg::ADDR_CTRL2) ?
                   saipc_pkg::CTRL2_WMASK : saipc_pkg::CTRL3_WMASK;

   // Time and code of the last start.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gap_ff <= 16'hFFFF;
         lastOs_ff <= 3'h0;
      end else begin
         gap_ff <= nxt_gap;
         if (measStart && clkEn) begin
            lastOs_ff <= measOsCode;
         end
      end
   end

   // Request steps.
   sequence s_c3wr;
      regWrEn && clkEn && regAddr == saipc_pkg::ADDR_CTRL3 &&
      $stable(irqAReq) && $stable(irqBReq);
   endsequence
   sequence s_c1wr;
      regWrEn && clkEn && regAddr == saipc_pkg::ADDR_CTRL1 ##1 !regWrEn;
   endsequence
   sequence s_rsvrd;
      regRdEn && clkEn && (regAddr == saipc_pkg::ADDR_CTRL2 ||
                           regAddr == saipc_pkg::ADDR_CTRL3);
   endsequence

   chk_drive_next_cycle: assert property (s_c3wr |=>
      irqPinAPullUp == !$past(regWrData[4]) &&
      irqPinBPullUp == !$past(regWrData[0]))
      else $error("drive mode late");
   chk_pola_level: assert property (
      s_c3wr ##0 !regWrData[4] |=>
      irqPinAOut == $past(irqAReq ~^ regWrData[5]))
      else $error("pin A level");
   chk_polb_level: assert property (
      s_c3wr ##0 !regWrData[0] |=>
      irqPinBOut == $past(irqBReq ~^ regWrData[1]))
      else $error("pin B level");
   chk_pina_drive: assert property (
      irqPinAPullUp ? !irqPinAOeN : !irqPinAOut)
      else $error("pin A drive");
   chk_pinb_drive: assert property (
      irqPinBPullUp ? !irqPinBOeN : !irqPinBOut)
      else $error("pin B drive");
   chk_start_pulse: assert property (measStart && clkEn |->
      measBusy ##1 !measStart)
      else $error("start pulse");
   chk_busy_ends: assert property (
      measBusy && measDone && clkEn |=> !measBusy)
      else $error("busy stuck");
   chk_sample_spacing: assert property (
      measStart |-> 32'(gap_ff) >= minGap)
      else $error("spacing short");
   chk_resv_zero: assert property (s_rsvrd |=>
      (regRdData & ~$past(rdMask)) == 8'h00)
      else $error("reserved nonzero");
   chk_os_copy: assert property (s_c1wr |=>
      measOsCode == $past(regWrData[5:3], 2))
      else $error("code not copied");
endmodule
`default_nettype wire

bind saipc_top saipc_top_checker #(.TICKS_PER_MS(TICKS_PER_MS)) chk (
   .sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
   .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
   .regRdData(regRdData), .measStart(measStart), .measOsCode(measOsCode),
   .measBusy(measBusy), .measDone(measDone), .irqAReq(irqAReq),
   .irqBReq(irqBReq), .irqPinAOut(irqPinAOut), .irqPinAOeN(irqPinAOeN),
   .irqPinAPullUp(irqPinAPullUp), .irqPinBOut(irqPinBOut),
   .irqPinBOeN(irqPinBOeN), .irqPinBPullUp(irqPinBPullUp));

// *** verif/saipc_top_tb.sv ***
/* Bench of saipc_top with the measurement model.
   Assumes TICKS_PER_MS of 4. */
`timescale 1ns/1ps
`default_nettype none
module saipc_top_tb;
   localparam int unsigned TPM = 4;
   localparam logic [7:0] C1 = saipc_pkg::ADDR_CTRL1;
   localparam logic [7:0] C2 = saipc_pkg::ADDR_CTRL2;
   localparam logic [7:0] C3 = saipc_pkg::ADDR_CTRL3;
   logic        sys_clk, reset, regWrEn, regRdEn;
   logic [7:0]  regAddr, regWrData, regRdData;
   logic        measStart, measBusy, measDone, capturedValid;
   logic [2:0]  measOsCode;
   logic [19:0] resultPressure, progPressTarget, targetPressure, nextP;
   logic [11:0] resultTemp, progTempTarget, targetTemp, nextT;
   logic        irqAReq, irqBReq, irqPinAOut, irqPinAOeN, irqPinAPullUp;
   logic        irqPinBOut, irqPinBOeN, irqPinBPullUp;
   int          fail_count, checks;
   // Packed views for the checks.
   wire [5:0]   pins = {irqPinAOut, irqPinAOeN, irqPinAPullUp, irqPinBOut,
                        irqPinBOeN, irqPinBPullUp};
   wire [31:0]  tgt = {targetPressure, targetTemp};

   saipc_top #(.TICKS_PER_MS(TPM)) dut (
      .sys_clk(sys_clk), .reset(reset), .clkEn(1'b1), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
      .regRdData(regRdData), .measStart(measStart),
      .measOsCode(measOsCode), .measBusy(measBusy), .measDone(measDone),
      .resultPressure(resultPressure), .resultTemp(resultTemp),
      .progPressTarget(progPressTarget), .progTempTarget(progTempTarget),
      .targetPressure(targetPressure), .targetTemp(targetTemp),
      .capturedValid(capturedValid), .irqAReq(irqAReq), .irqBReq(irqBReq),
      .irqPinAOut(irqPinAOut), .irqPinAOeN(irqPinAOeN),
      .irqPinAPullUp(irqPinAPullUp), .irqPinBOut(irqPinBOut),
      .irqPinBOeN(irqPinBOeN), .irqPinBPullUp(irqPinBPullUp));

   saipc_meas_model model (
      .sys_clk(sys_clk), .reset(reset), .measStart(measStart),
      .nextP(nextP), .nextT(nextT), .measDone(measDone),
      .resultPressure(resultPressure), .resultTemp(resultTemp));

   // Free-running 200 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge sys_clk);
      regWrEn = 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge sys_clk);
      regRdEn = 1'b0;
      chk(32'(regRdData), 32'(e));
   endtask

   // Wait for a start; n is 9000 if none comes.
   task automatic wst(output int n);
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (!measStart && n < 9000);
   endtask

   task automatic shot(input logic [2:0] os);
      int n;
      wr(C1, {2'b00, os, 3'b010});
      wst(n);
      chk(32'(measOsCode), 32'(os));
      n = 0;
      while (measBusy && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
   endtask

   // Expected {out, oeN, pullUp} for {polarity, drive, request}.
   function automatic logic [2:0] pexp(input logic [2:0] v);
      logic lvl;
      lvl = v[0] ? v[2] : !v[2];
      return v[1] ? {1'b0, lvl, 1'b0} : {lvl, 1'b0, 1'b1};
   endfunction

   task automatic t_reset();
      rdc(C1, 8'h00);
      rdc(C2, 8'h00);
      rdc(C3, 8'h00);
      rdc(8'h40, 8'h00);
      chk(32'(pins), 32'h0000_002D);
   endtask

   task automatic t_target();
      chk(tgt, 32'h1234_5ABC);
      nextP = 20'hA_0001;
      nextT = 12'h011;
      wr(C2, 8'h30);
      shot(3'h0);
      chk(tgt, 32'hA000_1011);
      nextP = 20'hB_0002;
      nextT = 12'h022;
      shot(3'h0);
      chk(tgt, 32'hA000_1011);
      wr(C2, 8'h10);
      wr(C2, 8'h30);
      shot(3'h0);
      chk(tgt, 32'hB000_2022);
      wr(C2, 8'h00);
      @(negedge sys_clk);
      chk(tgt, 32'h1234_5ABC);
      chk(32'(capturedValid), 32'h0000_0001);
   endtask

   task automatic t_shots();
      for (int i = 0; i < 8; i++) begin
         shot(3'(i));
         rdc(C1, {2'b00, 3'(i), 3'b000});
      end
   endtask

   task automatic t_pins();
      logic [2:0] a;
      logic [2:0] b;
      for (int i = 0; i < 8; i++) begin
         a = 3'(i);
         b = a ^ 3'b110;
         @(negedge sys_clk);
         irqAReq = a[0];
         irqBReq = b[0];
         wr(C3, {2'b00, a[2:1], 2'b00, b[2:1]});
         chk(32'(pins), 32'({pexp(a), pexp(b)}));
      end
      wr(C3, 8'h00);
   endtask

   task automatic t_resv();
      wr(C2, 8'hFF);
      rdc(C2, 8'h3F);
      wr(C3, 8'hFF);
      rdc(C3, 8'h33);
      wr(8'h40, 8'hFF);
      rdc(8'h40, 8'h00);
      wr(C2, 8'h00);
      wr(C3, 8'h00);
   endtask

   task automatic t_active();
      int n;
      wr(C1, 8'h01);
      wst(n);
      wst(n);
      chk(32'(n >= 4000 && n <= 4000 + 2 * TPM), 32'h0000_0001);
      wr(C1, 8'h03);
      wst(n);
      repeat (40) @(negedge sys_clk);
      rdc(C1, 8'h03);
      wr(C1, 8'h00);
      wst(n);
      chk(32'(n), 32'h0000_2328);
   endtask

   task automatic finish_test();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watchdog: tests need about 20000 cycles.
   initial begin
      #300000;
      fail_count++;
      finish_test();
   end

   // Inputs change on the falling edge.
   initial begin
      reset = 1'b1;
      {regWrEn, regRdEn, irqAReq, irqBReq} = 4'h0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      progPressTarget = 20'h1_2345;
      progTempTarget = 12'hABC;
      nextP = 20'h0_0000;
      nextT = 12'h000;
      fail_count = 0;
      checks = 0;
      repeat (5) @(negedge sys_clk);
      reset = 1'b0;
      t_reset();
      t_target();
      t_shots();
      t_pins();
      t_resv();
      t_active();
      finish_test();
   end
endmodule
`default_nettype wire
